/* rtl/scmr_pkg.sv */
package scmr_pkg;
    localparam int SCMR_ADDR_W = 19;
    localparam int SCMR_PAGE_W = 2;
    localparam int SCMR_DIV = 4;
    localparam int SCMR_POR_CYCLES = 16;
    localparam logic [SCMR_ADDR_W-1:0] SCMR_ADDR_RST = 19'h00000;
endpackage

/* rtl/scmr_if.sv */
`timescale 1ns/1ns
interface scmr_if;
    logic serial_bit_clock;
    logic chip_select_n;
    logic reset_oe_n;
    logic program_mode_enable_n;
    logic page_enable;
    logic [1:0] page_choice_bits;
    logic data_out;
    logic data_oe;
    logic chain_next_select_n;
    logic ready_oe;
    modport device (
        input serial_bit_clock, chip_select_n, reset_oe_n, program_mode_enable_n,
        input page_enable, page_choice_bits,
        output data_out, data_oe, chain_next_select_n, ready_oe
    );
    modport host (
        output serial_bit_clock, chip_select_n, reset_oe_n, program_mode_enable_n,
        output page_enable, page_choice_bits,
        input data_out, data_oe, chain_next_select_n, ready_oe
    );
endinterface

/* rtl/scmr_device.sv */
`timescale 1ns/1ns
module scmr_device
    import scmr_pkg::*;
#(
    parameter int ADDR_W = SCMR_ADDR_W,
    parameter int POR_CYCLES = SCMR_POR_CYCLES
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // link
    scmr_if.device link,
    // memory read port
    output logic [ADDR_W-1:0] o_mem_addr,
    input wire logic i_mem_bit,
    // status
    output logic o_program_mode,
    output logic o_standby
);
    initial begin
        if (ADDR_W < 3 || POR_CYCLES < 1 || POR_CYCLES > 255) begin
            $error("scmr_device: bad parameters");
        end
    end
    typedef struct packed {
        logic [1:0] s_clk;
        logic [1:0] s_cs;
        logic [1:0] s_oe;
        logic [1:0] s_pm;
        logic [1:0] s_pe;
        logic [3:0] s_pg;
        logic clk_d;
        logic [7:0] por;
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] ofs;
        logic done;
        logic casc_n;
        logic data;
        logic data_oe;
        logic ready_oe;
        logic pm;
        logic stby;
    } scmr_dev_t;
    scmr_dev_t r, next_r;
    logic [ADDR_W-1:0] base, span;
    logic sel, rise;
    // range from paging inputs
    always_comb begin
        base = '0;
        span = '1;
        if (r.s_pe[1]) begin
            base = {r.s_pg[3:2], {(ADDR_W-2){1'b0}}};
            span = {2'b00, {(ADDR_W-2){1'b1}}};
        end
    end
    assign sel = !r.s_cs[1] && r.s_oe[1] && r.s_pm[1];
    assign rise = r.s_clk[1] && !r.clk_d;
    // pins pass two flops; bits 1 of each pair, and bits 3:2 of s_pg, feed logic only
    always_comb begin
        next_r = r;
        next_r.s_clk = {r.s_clk[0], link.serial_bit_clock};
        next_r.s_cs = {r.s_cs[0], link.chip_select_n};
        next_r.s_oe = {r.s_oe[0], link.reset_oe_n};
        next_r.s_pm = {r.s_pm[0], link.program_mode_enable_n};
        next_r.s_pe = {r.s_pe[0], link.page_enable};
        next_r.s_pg = {r.s_pg[1:0], link.page_choice_bits};
        next_r.clk_d = r.s_clk[1];
        if (r.por != 8'(POR_CYCLES)) next_r.por = r.por + 8'h01;
        next_r.ready_oe = (r.por != 8'(POR_CYCLES));
        next_r.pm = !r.s_pm[1];
        next_r.stby = r.s_pm[1] && r.s_cs[1];
        if (!r.s_oe[1] || r.ready_oe) begin
            next_r.ofs = '0;
            next_r.done = 1'b0;
        end else if (sel && rise && !r.done) begin
            // the rise that takes the top bit ends the range; no wrap
            if (r.ofs == span) next_r.done = 1'b1;
            else next_r.ofs = r.ofs + 1'b1;
        end
        // counter is an offset into the range, so a page change needs no reload
        next_r.addr = base | next_r.ofs;
        // cascade low at top while enabled; follows select thereafter
        next_r.casc_n = !(r.done && !r.s_cs[1] && r.s_oe[1]);
        next_r.data = i_mem_bit;
        next_r.data_oe = sel && !r.done && !r.ready_oe;
    end
    // state register
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            r <= '0;
            r.s_clk <= 2'h0;
            r.s_cs <= 2'h3;
            r.s_oe <= 2'h0;
            r.s_pm <= 2'h3;
            r.addr <= ADDR_W'(SCMR_ADDR_RST);
            r.casc_n <= 1'b1;
            r.ready_oe <= 1'b1;
        end else begin
            r <= next_r;
        end
    end
    assign o_mem_addr = r.addr;
    assign o_program_mode = r.pm;
    assign o_standby = r.stby;
    assign link.data_out = r.data;
    assign link.data_oe = r.data_oe;
    assign link.chain_next_select_n = r.casc_n;
    assign link.ready_oe = r.ready_oe;
endmodule // scmr_device

/* rtl/scmr_host.sv */
`timescale 1ns/1ns
module scmr_host
    import scmr_pkg::*;
#(
    parameter int DIV = SCMR_DIV
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // link
    scmr_if.host link,
    // user control
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic i_page_enable,
    input wire logic [1:0] i_page_choice,
    input wire logic i_program_mode,
    // user stream
    output logic o_bit_valid,
    output logic o_bit,
    output logic o_busy
);
    initial begin
        if (DIV < 2 || DIV > 255) $error("scmr_host: bad divider");
    end
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_RUN = 3'b010,
        S_RST = 3'b100
    } scmr_st_t;
    typedef struct packed {
        scmr_st_t st;
        logic [7:0] div;
        logic clk;
        logic cs_n;
        logic oe;
        logic pm_n;
        logic pe;
        logic [1:0] pg;
        logic [1:0] s_d;
        logic [1:0] s_en;
        logic bv;
        logic b;
        logic seen;
        logic busy;
    } scmr_host_t;
    scmr_host_t r, next_r;
    // the host fetches the stream itself, no controller in between
    always_comb begin
        next_r = r;
        next_r.bv = 1'b0;
        next_r.pm_n = !i_program_mode;
        next_r.pe = i_page_enable;
        next_r.pg = i_page_choice;
        next_r.s_d = {r.s_d[0], link.data_out};
        next_r.s_en = {r.s_en[0], link.data_oe};
        unique case (r.st)
            S_IDLE: begin
                next_r.clk = 1'b0;
                next_r.cs_n = 1'b1;
                next_r.seen = 1'b0;
                if (i_start && !i_program_mode) begin
                    next_r.st = S_RUN;
                    next_r.cs_n = 1'b0;
                    next_r.oe = 1'b1;
                    next_r.div = 8'h00;
                end
            end
            S_RUN: begin
                next_r.div = r.div + 8'h01;
                if (r.s_en[1]) next_r.seen = 1'b1;
                if (r.div == 8'(DIV - 1)) begin
                    next_r.div = 8'h00;
                    // first rise waits for the driver, else bit 0 is clocked away unseen
                    if (r.clk || r.seen || r.s_en[1]) begin
                        next_r.clk = !r.clk;
                        // sample just before the rising edge
                        if (!r.clk && r.s_en[1]) begin
                            next_r.bv = 1'b1;
                            next_r.b = r.s_d[1];
                        end
                    end
                end
                if (i_stop) begin
                    next_r.st = S_RST;
                    next_r.oe = 1'b0;
                    next_r.clk = r.clk; // hold: no short clock phase
                    next_r.div = 8'h00;
                end
            end
            S_RST: begin
                next_r.div = r.div + 8'h01;
                if (r.div == 8'(DIV - 1)) begin
                    next_r.st = S_IDLE;
                    next_r.oe = 1'b1;
                    next_r.cs_n = 1'b1;
                    next_r.clk = 1'b0;
                end
            end
        endcase
        next_r.busy = (next_r.st != S_IDLE);
    end
    // state register
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            r <= '0;
            r.st <= S_IDLE;
            r.cs_n <= 1'b1;
            r.oe <= 1'b1;
            r.pm_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end
    assign link.serial_bit_clock = r.clk;
    assign link.chip_select_n = r.cs_n;
    assign link.reset_oe_n = r.oe;
    assign link.program_mode_enable_n = r.pm_n;
    assign link.page_enable = r.pe;
    assign link.page_choice_bits = r.pg;
    assign o_bit_valid = r.bv;
    assign o_bit = r.b;
    assign o_busy = r.busy;
endmodule // scmr_host

/* dv/scmr_sva.sv */
`timescale 1ns/1ns
module scmr_sva (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // link
    input wire logic serial_bit_clock,
    input wire logic chip_select_n,
    input wire logic reset_oe_n,
    input wire logic program_mode_enable_n,
    input wire logic data_oe,
    input wire logic chain_next_select_n,
    input wire logic ready_oe
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // repeats leave room for the two-flop input sync
    property p_stby; chip_select_n[*5] |-> !data_oe; endproperty
    a_stby: assert property (p_stby) else $error("data in standby");
    property p_rst; !reset_oe_n[*5] |-> !data_oe && chain_next_select_n; endproperty
    a_rst: assert property (p_rst) else $error("reset ignored");
    property p_prog; !program_mode_enable_n[*5] |-> !data_oe; endproperty
    a_prog: assert property (p_prog) else $error("data in prog mode");
    property p_casc; !chain_next_select_n |-> !data_oe; endproperty
    a_casc: assert property (p_casc) else $error("data with cascade");
    property p_follow; chip_select_n[*5] |-> chain_next_select_n; endproperty
    a_follow: assert property (p_follow) else $error("cascade stuck");
    property p_drive;
        (!chip_select_n && reset_oe_n && program_mode_enable_n && !ready_oe
            && chain_next_select_n)[*6] |-> data_oe;
    endproperty
    a_drive: assert property (p_drive) else $error("data not driven");
    property p_rdy; $fell(i_rst) |-> ready_oe[*8]; endproperty
    a_rdy: assert property (p_rdy) else $error("ready early");
    property p_rdy_go; $fell(i_rst) |-> ##[1:24] !ready_oe; endproperty
    a_rdy_go: assert property (p_rdy_go) else $error("ready stuck");
    property p_clk; $rose(serial_bit_clock) |=> serial_bit_clock[*2]; endproperty
    a_clk: assert property (p_clk) else $error("short clock high");
    // main scenarios reached
    c_casc: cover property ($fell(chain_next_select_n));
    c_rdy: cover property ($fell(ready_oe));
    c_drive: cover property ($rose(data_oe));
endmodule // scmr_sva

/* dv/tb_serial_config_memory_readout.sv */
`timescale 1ns/1ns
module tb_serial_config_memory_readout;
    import scmr_pkg::*;
    localparam int AW = 6;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_start = 1'b0;
    logic i_stop = 1'b0;
    logic i_page_enable = 1'b0;
    logic i_program_mode = 1'b0;
    logic [1:0] i_page_choice = 2'h0;
    logic [AW-1:0] mem_addr;
    logic [AW-1:0] mask = '0;
    logic o_bit_valid, o_bit, o_busy, prog, stby;
    logic [31:0] rng = 32'h973D;
    int err_total = 0;
    int cmp_count = 0;
    logic got[$];
    scmr_if link ();
    // memory content is a random parity pattern of the address
    scmr_device #(.ADDR_W(AW)) scmr_device_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .link(link), .o_mem_addr(mem_addr), .i_mem_bit(^(mem_addr & mask)),
        .o_program_mode(prog), .o_standby(stby));
    scmr_host scmr_host_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .link(link),
        .i_start(i_start), .i_stop(i_stop), .i_page_enable(i_page_enable),
        .i_page_choice(i_page_choice), .i_program_mode(i_program_mode),
        .o_bit_valid(o_bit_valid), .o_bit(o_bit), .o_busy(o_busy));
    scmr_sva scmr_sva_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .serial_bit_clock(link.serial_bit_clock), .chip_select_n(link.chip_select_n),
        .reset_oe_n(link.reset_oe_n), .program_mode_enable_n(link.program_mode_enable_n),
        .data_oe(link.data_oe), .chain_next_select_n(link.chain_next_select_n),
        .ready_oe(link.ready_oe));
    always #20 i_ref_clk = ~i_ref_clk;
    // collect the stream as the host hands it up
    always @(posedge i_ref_clk) begin
        if (o_bit_valid === 1'b1) got.push_back(o_bit);
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic chk(input logic exp, input logic act);
        cmp_count++;
        if (act !== exp) begin
            err_total++;
            $display("[ERR] %0t exp %b got %b", $time, exp, act);
        end
    endtask
    // inputs move 2 ns after the edge, never on it
    task automatic step(input int n);
        repeat (n) @(posedge i_ref_clk);
        #2;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
    endtask
    // one readout: model range from page bits, then stop resets counter
    task automatic run(input logic pe, input logic [1:0] pg);
        int n;
        int base;
        n = pe ? (1 << (AW - 2)) : (1 << AW);
        base = pe ? pg * n : 0;
        mask = rng[AW-1:0];
        i_page_enable = pe;
        i_page_choice = pg;
        got.delete();
        pulse(i_start);
        for (int t = 0; t < 2000 && link.chain_next_select_n !== 1'b0; t++) step(1);
        chk(1'b0, link.chain_next_select_n);
        chk(1'b0, link.data_oe);
        chk(1'b1, got.size() == n);
        for (int k = 0; k < n; k++) chk(^((base + k) & mask), got[k]);
        pulse(i_stop);
        for (int t = 0; t < 200 && o_busy !== 1'b0; t++) step(1);
        step(4);
        chk(1'b1, link.chain_next_select_n);
        chk(1'b1, link.reset_oe_n);
        chk(1'b1, stby);
        $display("run paging %0b page %0d bits %0d ended", pe, pg, n);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // watchdog: the runs need under 2000 cycles
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        err_total++;
        results();
    end
    initial begin
        step(20);
        i_rst = 1'b0;
        step(1);
        chk(1'b1, link.ready_oe);
        step(30);
        chk(1'b0, link.ready_oe);
        for (int k = 0; k < 6; k++) begin
            rng = xs(rng);
            run(k == 4 ? 1'b0 : (k < 4 ? 1'b1 : rng[8]), k < 4 ? k[1:0] : rng[5:4]);
        end
        i_program_mode = 1'b1;
        pulse(i_start);
        step(20);
        chk(1'b1, prog);
        chk(1'b0, link.data_oe);
        $display("program mode test ended");
        results();
    end
endmodule // tb_serial_config_memory_readout
